// ---- pcae_pkg.sv ----
// package: constants and carrier types for the power calculation engine
package pcae_pkg;

    localparam int unsigned SAMPLE_WIDTH = 16;
    localparam int unsigned ACC_WIDTH    = 26;
    localparam int unsigned TOT_WIDTH    = 48;
    localparam int unsigned CNT_WIDTH    = 11;
    localparam int unsigned COEF_WIDTH   = 16;

    localparam logic [CNT_WIDTH-1:0]  AVG_MAX       = 11'h400;
    localparam logic [CNT_WIDTH-1:0]  AVG_ONE       = 11'h001;
    localparam logic [CNT_WIDTH-1:0]  CNT_RESET     = 11'h000;
    localparam logic [ACC_WIDTH-1:0]  ACC_RESET     = 26'h0;
    localparam logic [TOT_WIDTH-1:0]  TOT_RESET     = 48'h0;
    localparam logic [SAMPLE_WIDTH-1:0] OUT_RESET   = 16'h0;
    localparam logic [31:0]           PWR_RESET     = 32'h0;
    localparam logic [COEF_WIDTH-1:0] COEF_UNITY    = 16'h8000;
    localparam int unsigned           COEF_SHIFT    = 15;
    localparam int unsigned           TEMP_IDX_MSB  = 15;
    localparam int unsigned           TEMP_IDX_LSB  = 12;

    typedef enum logic [1:0]
    {
        PCAE_CH_TEMP,
        PCAE_CH_SHUNT,
        PCAE_CH_BUS
    } pcae_chan_type;

    typedef enum logic [2:0]
    {
        PCAE_IDLE,
        PCAE_TEMP,
        PCAE_SHUNT,
        PCAE_BUS,
        PCAE_FINISH
    } pcae_state_type;

    // converter request and answer
    typedef struct packed
    {
        logic                    start;
        pcae_chan_type           chan;
    } pcae_conv_req_type;

    typedef struct packed
    {
        logic                    done;
        logic [SAMPLE_WIDTH-1:0] data;
    } pcae_conv_ans_type;

    // readable results
    typedef struct packed
    {
        logic [SAMPLE_WIDTH-1:0] current;
        logic [SAMPLE_WIDTH-1:0] voltage;
        logic [SAMPLE_WIDTH-1:0] temp;
        logic [31:0]             power;
        logic [TOT_WIDTH-1:0]    energy;
        logic [TOT_WIDTH-1:0]    charge;
        logic                    ready;
    } pcae_result_type;

endpackage

// ---- pcae_engine.sv ----
// module: measurement sequencer, averaging and power/energy/charge engine
`timescale 1ns/1ns

// Operation
// - shunt, bus and temperature share one converter through a selector, one channel at a time.
// - current and charge come from the shunt sample; power and energy follow a bus sample.
// - energy, and power at an average count of one, use the latest current value with the newest bus sample.
// - with an average count of one, each result goes straight to its output.
// - with averaging on, each sample adds into its accumulator until the count is met.
// - after the last sample, averages are formed, power computed, outputs updated.
// - energy and charge accumulate once per conversion cycle and are never averaged.
// - calculations run alongside conversions; only the finish step adds one cycle to each sequence.
// - each current is corrected by a factor picked from the latest temperature sample.
// - continuous and triggered operation are selected by an input.
// - a temperature conversion precedes every current conversion.
// - the average count runs from 1 to 1024, the same for all inputs.
module pcae_engine
(
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              continuous_mode,
    input  wire logic                              trigger,
    input  wire logic [pcae_pkg::CNT_WIDTH-1:0]    avg_count,
    input  wire logic [pcae_pkg::COEF_WIDTH*16-1:0] temp_coef_table,
    output logic                                   conv_start,
    output pcae_pkg::pcae_chan_type                conv_chan,
    input  wire logic                              conv_done,
    input  wire logic [pcae_pkg::SAMPLE_WIDTH-1:0] conv_data,
    output pcae_pkg::pcae_result_type              result,
    output logic                                   busy
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed
    {
        pcae_pkg::pcae_state_type               state;
        logic                                   started;
        logic                                   running;
        logic [pcae_pkg::CNT_WIDTH-1:0]         count;
        logic [pcae_pkg::CNT_WIDTH-1:0]         target;
        logic signed [pcae_pkg::SAMPLE_WIDTH-1:0] temp_last;
        logic signed [pcae_pkg::SAMPLE_WIDTH-1:0] curr_last;
        logic signed [pcae_pkg::ACC_WIDTH-1:0]  acc_curr;
        logic signed [pcae_pkg::ACC_WIDTH-1:0]  acc_volt;
        logic signed [pcae_pkg::ACC_WIDTH-1:0]  acc_temp;
        logic                                   conv_start;
        pcae_pkg::pcae_chan_type                conv_chan;
        pcae_pkg::pcae_result_type              result;
    } pcae_regs_type;

    pcae_regs_type regs_reg;
    pcae_regs_type regs_next;

    logic signed [pcae_pkg::COEF_WIDTH:0]          coef;
    logic signed [pcae_pkg::SAMPLE_WIDTH+pcae_pkg::COEF_WIDTH:0] corr_prod;
    logic signed [pcae_pkg::SAMPLE_WIDTH-1:0]      curr_comp;
    logic signed [pcae_pkg::ACC_WIDTH-1:0]         sum_curr;
    logic signed [pcae_pkg::ACC_WIDTH-1:0]         sum_volt;
    logic signed [pcae_pkg::ACC_WIDTH-1:0]         sum_temp;
    logic signed [pcae_pkg::SAMPLE_WIDTH-1:0]      avg_curr;
    logic signed [pcae_pkg::SAMPLE_WIDTH-1:0]      avg_volt;
    logic signed [pcae_pkg::SAMPLE_WIDTH-1:0]      avg_temp;
    logic signed [31:0]                            pwr_now;
    logic [pcae_pkg::CNT_WIDTH-1:0]                avg_clamped;
    logic [3:0]                                    coef_idx;

    // ----------------------------------------
    // combinational helpers
    // ----------------------------------------
    // out-of-range counts are clamped, zero treated as one
    always_comb
    begin
        if (avg_count == pcae_pkg::CNT_RESET)
        begin
            avg_clamped = pcae_pkg::AVG_ONE;
        end
        else if (avg_count > pcae_pkg::AVG_MAX)
        begin
            avg_clamped = pcae_pkg::AVG_MAX;
        end
        else
        begin
            avg_clamped = avg_count;
        end
    end

    // factor looked up from the upper bits of the last temperature sample
    assign coef_idx  = regs_reg.temp_last[pcae_pkg::TEMP_IDX_MSB:pcae_pkg::TEMP_IDX_LSB];
    assign coef      = {1'b0, temp_coef_table[coef_idx*pcae_pkg::COEF_WIDTH +:
                        pcae_pkg::COEF_WIDTH]};
    assign corr_prod = $signed(conv_data) * coef;
    assign curr_comp = corr_prod[pcae_pkg::COEF_SHIFT +: pcae_pkg::SAMPLE_WIDTH];

    // current and voltage sums include the sample arriving this cycle; sum_temp is the stored sum only
    assign sum_curr = regs_reg.acc_curr + pcae_pkg::ACC_WIDTH'(curr_comp);
    assign sum_volt = regs_reg.acc_volt + pcae_pkg::ACC_WIDTH'($signed(conv_data));
    assign sum_temp = regs_reg.acc_temp;

    // division by a non power of two count is costly; a shift by the
    // count's trailing zero bits (its lowest set bit) keeps it cheap and is exact for power-of-two counts
    function automatic logic signed [pcae_pkg::SAMPLE_WIDTH-1:0] avg_of
    (
        input logic signed [pcae_pkg::ACC_WIDTH-1:0] sum,
        input logic [pcae_pkg::CNT_WIDTH-1:0]        n
    );
        logic signed [pcae_pkg::ACC_WIDTH-1:0] q;
        q = sum;
        for (int i = pcae_pkg::CNT_WIDTH - 1; i >= 1; i--)
        begin
            if (n[i] && (n & ((pcae_pkg::CNT_WIDTH'(1) << i) - 1'b1)) == '0)
            begin
                q = sum >>> i;
            end
        end
        return q[pcae_pkg::SAMPLE_WIDTH-1:0];
    endfunction

    assign avg_curr = avg_of(regs_reg.acc_curr, regs_reg.target);
    // stored sum only: the finish cycle carries no fresh bus sample
    assign avg_volt = avg_of(regs_reg.acc_volt, regs_reg.target);
    assign avg_temp = avg_of(sum_temp, regs_reg.target);
    assign pwr_now  = regs_reg.curr_last * $signed(conv_data);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb
    begin
        regs_next            = regs_reg;
        regs_next.conv_start = 1'b0;

        // a trigger restarts any sequence in progress
        if (trigger)
        begin
            regs_next.running  = 1'b1;
            regs_next.started  = 1'b0;
            regs_next.count    = pcae_pkg::CNT_RESET;
            regs_next.target   = avg_clamped;
            regs_next.acc_curr = pcae_pkg::ACC_RESET;
            regs_next.acc_volt = pcae_pkg::ACC_RESET;
            regs_next.acc_temp = pcae_pkg::ACC_RESET;
            regs_next.state    = pcae_pkg::PCAE_TEMP;
            regs_next.result.ready = 1'b0;
        end
        else
        begin
            case (regs_reg.state)
                pcae_pkg::PCAE_IDLE:
                begin
                    if (continuous_mode)
                    begin
                        regs_next.running = 1'b1;
                        regs_next.target  = avg_clamped;
                        regs_next.state   = pcae_pkg::PCAE_TEMP;
                    end
                end
                pcae_pkg::PCAE_TEMP:
                begin
                    if (!regs_reg.started)
                    begin
                        regs_next.conv_start = 1'b1;
                        regs_next.conv_chan  = pcae_pkg::PCAE_CH_TEMP;
                        regs_next.started    = 1'b1;
                    end
                    else if (conv_done)
                    begin
                        regs_next.temp_last = conv_data;
                        regs_next.acc_temp  = regs_reg.acc_temp
                                              + pcae_pkg::ACC_WIDTH'($signed(conv_data));
                        if (regs_reg.target == pcae_pkg::AVG_ONE)
                        begin
                            regs_next.result.temp = conv_data;
                        end
                        regs_next.started = 1'b0;
                        regs_next.state   = pcae_pkg::PCAE_SHUNT;
                    end
                end
                pcae_pkg::PCAE_SHUNT:
                begin
                    if (!regs_reg.started)
                    begin
                        regs_next.conv_start = 1'b1;
                        regs_next.conv_chan  = pcae_pkg::PCAE_CH_SHUNT;
                        regs_next.started    = 1'b1;
                    end
                    else if (conv_done)
                    begin
                        regs_next.curr_last = curr_comp;
                        regs_next.acc_curr  = sum_curr;
                        // charge once per cycle, no averaging
                        regs_next.result.charge = regs_reg.result.charge
                            + pcae_pkg::TOT_WIDTH'(curr_comp);
                        if (regs_reg.target == pcae_pkg::AVG_ONE)
                        begin
                            regs_next.result.current = curr_comp;
                        end
                        regs_next.started = 1'b0;
                        regs_next.state   = pcae_pkg::PCAE_BUS;
                    end
                end
                pcae_pkg::PCAE_BUS:
                begin
                    if (!regs_reg.started)
                    begin
                        regs_next.conv_start = 1'b1;
                        regs_next.conv_chan  = pcae_pkg::PCAE_CH_BUS;
                        regs_next.started    = 1'b1;
                    end
                    else if (conv_done)
                    begin
                        // energy in the same cycle the bus sample lands
                        regs_next.result.energy = regs_reg.result.energy
                            + pcae_pkg::TOT_WIDTH'(pwr_now);
                        regs_next.acc_volt = sum_volt;
                        regs_next.count    = regs_reg.count + 1'b1;
                        regs_next.started  = 1'b0;
                        if (regs_reg.target == pcae_pkg::AVG_ONE)
                        begin
                            regs_next.result.voltage = conv_data;
                            regs_next.result.power   = pwr_now;
                            regs_next.result.ready   = 1'b1;
                            regs_next.state          = pcae_pkg::PCAE_FINISH;
                        end
                        else if (regs_reg.count + 1'b1 >= regs_reg.target)
                        begin
                            regs_next.state = pcae_pkg::PCAE_FINISH;
                        end
                        else
                        begin
                            regs_next.state = pcae_pkg::PCAE_TEMP;
                        end
                    end
                end
                pcae_pkg::PCAE_FINISH:
                begin
                    if (regs_reg.target != pcae_pkg::AVG_ONE)
                    begin
                        regs_next.result.current = avg_curr;
                        regs_next.result.voltage = avg_volt;
                        regs_next.result.temp    = avg_temp;
                        regs_next.result.power   = avg_curr * avg_volt;
                        regs_next.result.ready   = 1'b1;
                    end
                    regs_next.acc_curr = pcae_pkg::ACC_RESET;
                    regs_next.acc_volt = pcae_pkg::ACC_RESET;
                    regs_next.acc_temp = pcae_pkg::ACC_RESET;
                    regs_next.count    = pcae_pkg::CNT_RESET;
                    regs_next.target   = avg_clamped;
                    if (continuous_mode)
                    begin
                        regs_next.state = pcae_pkg::PCAE_TEMP;
                    end
                    else
                    begin
                        regs_next.running = 1'b0;
                        regs_next.state   = pcae_pkg::PCAE_IDLE;
                    end
                end
                default:
                begin
                    regs_next.state = pcae_pkg::PCAE_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            regs_reg.state      <= pcae_pkg::PCAE_IDLE;
            regs_reg.started    <= 1'b0;
            regs_reg.running    <= 1'b0;
            regs_reg.count      <= pcae_pkg::CNT_RESET;
            regs_reg.target     <= pcae_pkg::AVG_ONE;
            regs_reg.temp_last  <= pcae_pkg::OUT_RESET;
            regs_reg.curr_last  <= pcae_pkg::OUT_RESET;
            regs_reg.acc_curr   <= pcae_pkg::ACC_RESET;
            regs_reg.acc_volt   <= pcae_pkg::ACC_RESET;
            regs_reg.acc_temp   <= pcae_pkg::ACC_RESET;
            regs_reg.conv_start <= 1'b0;
            regs_reg.conv_chan  <= pcae_pkg::PCAE_CH_TEMP;
            regs_reg.result     <= '0;
        end
        else
        begin
            regs_reg <= regs_next;
        end
    end

    assign conv_start = regs_reg.conv_start;
    assign conv_chan  = regs_reg.conv_chan;
    assign result     = regs_reg.result;
    assign busy       = regs_reg.running;

endmodule

// ---- pcae_engine_assertions.sv ----
// checker: port properties of the power calculation engine
`timescale 1ns/1ns
module pcae_engine_assertions
(
    input wire logic                      core_clk,
    input wire logic                      rst,
    input wire logic                      trigger,
    input wire logic                      conv_start,
    input wire pcae_pkg::pcae_chan_type   conv_chan,
    input wire logic                      conv_done,
    input wire pcae_pkg::pcae_result_type result,
    input wire logic                      busy
);
    // ----------
    // properties
    // ----------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic                    pend_reg;
    pcae_pkg::pcae_chan_type last_reg;
    // a restart also clears pending, so its fresh start is legal
    always_ff @(posedge core_clk)
    begin
        pend_reg <= !rst && (conv_start || (pend_reg && !conv_done && !trigger));
        if (conv_start)
            last_reg <= conv_chan;
    end
    sequence s_shunt_req;
        conv_start && conv_chan == pcae_pkg::PCAE_CH_SHUNT;
    endsequence
    sequence s_bus_req;
        conv_start && conv_chan == pcae_pkg::PCAE_CH_BUS;
    endsequence
    sequence s_temp_done;
        conv_done && pend_reg && conv_chan == pcae_pkg::PCAE_CH_TEMP && !trigger;
    endsequence
    sequence s_shunt_done;
        conv_done && pend_reg && conv_chan == pcae_pkg::PCAE_CH_SHUNT && !trigger;
    endsequence
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    chk_one_pending: assert property (conv_start |-> !pend_reg)
        else $error("start while a conversion is pending");
    chk_temp_first: assert property (s_shunt_req |-> last_reg == pcae_pkg::PCAE_CH_TEMP)
        else $error("shunt conversion without temperature first");
    chk_shunt_follow: assert property (s_temp_done |-> ##[1:2] s_shunt_req)
        else $error("shunt start late after temperature");
    chk_bus_follow: assert property (s_shunt_done |-> ##[1:2] s_bus_req)
        else $error("bus start late after shunt");
    chk_trigger_start: assert property (trigger |-> ##[1:2] (conv_start && !conv_chan))
        else $error("trigger did not start a temperature conversion");
    chk_busy_start: assert property (conv_start |-> busy)
        else $error("start while not busy");
    chk_energy_src: assert property ($changed(result.energy) |->
        $past(conv_done) && $past(conv_chan) == pcae_pkg::PCAE_CH_BUS)
        else $error("energy moved without a bus sample");
    chk_charge_src: assert property ($changed(result.charge) |->
        $past(conv_done) && $past(conv_chan) == pcae_pkg::PCAE_CH_SHUNT)
        else $error("charge moved without a shunt sample");
    chk_output_hold: assert property ($changed(result.voltage) |->
        $past(conv_done) || $past(conv_done, 2))
        else $error("voltage output moved mid run");
endmodule
bind pcae_engine pcae_engine_assertions chk
(
    .core_clk(core_clk), .rst(rst), .trigger(trigger), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .result(result), .busy(busy)
);

// ---- pcae_conv_model.sv ----
// model: shared converter answering each start with a channel sample
`timescale 1ns/1ns
module pcae_conv_model
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    conv_start,
    input  wire pcae_pkg::pcae_chan_type conv_chan,
    input  wire logic                    slow,
    input  wire logic [15:0]             temp_val,
    input  wire logic [15:0]             shunt_val,
    input  wire logic [15:0]             bus_val,
    output logic                         conv_done,
    output logic [15:0]                  conv_data
);
    // -----------
    // answer path
    // -----------
    pcae_pkg::pcae_chan_type chan_hold = pcae_pkg::PCAE_CH_TEMP;
    logic                    seen;
    int                      wait_cnt  = 0;
    initial conv_done = 1'b0;
    initial conv_data = 16'h0;
    always @(posedge core_clk)
    begin
        seen = conv_start;
        if (seen)
            chan_hold = conv_chan;
        #1;
        conv_done = 1'b0;
        conv_data = ~conv_data; // inverted each cycle outside a done pulse, so the last sample shows every other cycle
        if (rst)
            wait_cnt = 0;
        else if (seen)
            wait_cnt = slow ? 1 + $urandom_range(5) : 1;
        else if (wait_cnt > 0)
        begin
            wait_cnt--;
            conv_done = (wait_cnt == 0);
            if (conv_done)
                conv_data = chan_hold == pcae_pkg::PCAE_CH_TEMP ? temp_val :
                            chan_hold == pcae_pkg::PCAE_CH_SHUNT ? shunt_val : bus_val;
        end
    end
endmodule

// ---- testbench.sv ----
// testbench: triggered, averaged and continuous runs against the engine
`timescale 1ns/1ns
module testbench;
    logic                               core_clk = 1'b0;
    logic                               rst      = 1'b1;
    logic                               cont     = 1'b0;
    logic                               trigger  = 1'b0;
    logic                               slow     = 1'b0;
    logic                               rdy_prev = 1'b0;
    logic [pcae_pkg::CNT_WIDTH-1:0]     avg_count = pcae_pkg::AVG_ONE;
    logic [pcae_pkg::COEF_WIDTH*16-1:0] coefs;
    logic                               conv_start, conv_done, busy;
    pcae_pkg::pcae_chan_type            conv_chan;
    logic [15:0]                        conv_data, t_val, s_val, b_val, cur_exp;
    logic [47:0]                        energy_exp = 48'h0, charge_exp = 48'h0;
    pcae_pkg::pcae_result_type          result, nt, got;
    pcae_pkg::pcae_result_type          notes [$];
    int                                 error_cnt  = 0, n_compared = 0;
    int                                 avg_tab [6] = '{1, 2, 4, 16, 0, 2047};
    // entry 1 halves the current, the rest are unity
    initial coefs = {{14{pcae_pkg::COEF_UNITY}}, 16'h4000, pcae_pkg::COEF_UNITY};
    initial {t_val, s_val, b_val, cur_exp} = 64'h0;
    always #2 core_clk = ~core_clk;
    pcae_engine dut (.core_clk(core_clk), .rst(rst), .continuous_mode(cont),
        .trigger(trigger), .avg_count(avg_count), .temp_coef_table(coefs),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
        .conv_data(conv_data), .result(result), .busy(busy));
    pcae_conv_model conv (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
        .conv_chan(conv_chan), .slow(slow), .temp_val(t_val), .shunt_val(s_val),
        .bus_val(b_val), .conv_done(conv_done), .conv_data(conv_data));
    // --------------
    // report helpers
    // --------------
    task end_sim;
        chk("pending results", 48'h0, 48'(notes.size()));
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string name, input logic [47:0] exp, input logic [47:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wait_idle;
        for (int i = 0; i < 40000 && busy !== 1'b0; i++)
            @(posedge core_clk);
        if (busy !== 1'b0)
        begin
            error_cnt++;
            end_sim();
        end
    endtask
    // values stay fixed over a run, so every power-of-two average is exact
    task run(input int n, input logic c);
        @(posedge core_clk);
        #1;
        t_val = {3'h0, 1'($urandom_range(1)), 12'($urandom)};
        s_val = {1'b0, 14'($urandom), 1'b0};
        b_val = {1'b0, 15'($urandom)};
        slow = 1'($urandom);
        cur_exp = t_val[12] ? s_val >> 1 : s_val;
        nt = '0;
        nt.current = cur_exp;
        nt.voltage = b_val;
        nt.temp = t_val;
        nt.power = cur_exp * b_val;
        notes.push_back(nt);
        avg_count = 11'(n);
        cont = c;
        trigger = 1'b1;
        @(posedge core_clk);
        #1;
        trigger = 1'b0;
        repeat (3) @(posedge core_clk);
        if (!c)
            wait_idle();
    endtask
    // -------
    // monitor
    // -------
    always @(posedge core_clk)
    begin
        if (conv_done === 1'b1 && conv_chan == pcae_pkg::PCAE_CH_SHUNT)
            charge_exp = charge_exp + cur_exp;
        if (conv_done === 1'b1 && conv_chan == pcae_pkg::PCAE_CH_BUS)
            energy_exp = energy_exp + cur_exp * b_val;
        if (result.ready === 1'b1 && rdy_prev !== 1'b1)
        begin
            got = result;
            nt = notes.size() > 0 ? notes.pop_front() : '1;
            chk("current", 48'(nt.current), 48'(got.current));
            chk("voltage", 48'(nt.voltage), 48'(got.voltage));
            chk("temp", 48'(nt.temp), 48'(got.temp));
            chk("power", 48'(nt.power), 48'(got.power));
            chk("charge", charge_exp, got.charge);
            chk("energy", energy_exp, got.energy);
        end
        rdy_prev = result.ready;
    end
    initial
    begin
        void'($urandom(23));
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        chk("reset energy", 48'h0, result.energy);
        chk("reset charge", 48'h0, result.charge);
        foreach (avg_tab[i])
            run(avg_tab[i], 1'b0);
        run(2, 1'b1);
        // let the loop repeat a few times before stopping it
        repeat (80) @(posedge core_clk);
        #1 cont = 1'b0;
        wait_idle();
        chk("loop energy", energy_exp, result.energy);
        chk("loop charge", charge_exp, result.charge);
        chk("loop voltage", 48'(b_val), 48'(result.voltage));
        end_sim();
    end
endmodule
